// ---- shared/tcr_pkg.sv ----
/*
  Constants, types and register map of the second 16-bit timer/counter.
  Assumes one oscillator clock drives the block; twelve oscillator
  periods make one machine cycle and two make one state time.
*/
package tcr_pkg;

  // ==========================================================
  // Register addresses in the special function space
  localparam logic [7:0] ADDR_CONTROL = 8'hC8;
  localparam logic [7:0] ADDR_MODE = 8'hC9;
  localparam logic [7:0] ADDR_HOLD_LOW = 8'hCA;
  localparam logic [7:0] ADDR_HOLD_HIGH = 8'hCB;
  localparam logic [7:0] ADDR_COUNT_LOW = 8'hCC;
  localparam logic [7:0] ADDR_COUNT_HIGH = 8'hCD;

  // ==========================================================
  // Control register field positions
  localparam int BIT_OVERFLOW = 7;
  localparam int BIT_EXTERNAL = 6;
  localparam int BIT_RX_CLOCK = 5;
  localparam int BIT_TX_CLOCK = 4;
  localparam int BIT_EXT_TRIG = 3;
  localparam int BIT_RUN = 2;
  localparam int BIT_COUNTER = 1;
  localparam int BIT_CAPTURE = 0;
  // Mode register field positions
  localparam int BIT_DOWN_EN = 0;
  localparam int BIT_OUT_EN = 1;

  // ==========================================================
  // Reset values and the all-ones count
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [1:0] RST_MODE = 2'h0;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] RST_UNMAPPED = 8'h00;
  localparam logic [15:0] COUNT_ALL_ONES = 16'hFFFF;

  // ==========================================================
  // Timing: oscillator periods per machine cycle and state time
  localparam int OSC_PER_CYCLE = 12;
  localparam int OSC_PER_STATE = 2;
  // Phase index = (state - 1) * 2 + (half - 1)
  localparam logic [3:0] PHASE_SAMPLE = 4'h9;
  localparam logic [3:0] PHASE_UPDATE = 4'h4;

  // ==========================================================
  // Types
  typedef struct packed {
    logic overflow_flag;
    logic external_flag;
    logic rx_clock_select;
    logic tx_clock_select;
    logic ext_trigger_enable;
    logic run_control;
    logic counter_select;
    logic capture_reload_select;
  } tcr_ctrl_s;

  typedef enum logic [3:0] {
    TCR_OFF = 4'h1,
    TCR_RELOAD = 4'h2,
    TCR_CAPTURE = 4'h4,
    TCR_BAUD = 4'h8
  } tcr_mode_e;

endpackage : tcr_pkg

// ---- verilog/tcr_phase.sv ----
/*
  Machine-cycle phase generator: counts oscillator periods within one
  machine cycle and flags state-time boundaries.
  Assumes a synchronous, already released reset.
*/
`timescale 1ns/1ps
`default_nettype none

module tcr_phase
  import tcr_pkg::*;
#(
  parameter int CYCLE_LEN = OSC_PER_CYCLE
) (
  input wire logic mclk,
  input wire logic rst_sync_n,
  output logic [3:0] phase,
  output logic state_tick
);

  // ==========================================================
  // Phase counter
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      phase <= 4'h0;
    end else if (phase == 4'(CYCLE_LEN - 1)) begin
      phase <= 4'h0;
    end else begin
      phase <= phase + 4'h1;
    end
  end

  // Odd phase closes a state time
  assign state_tick = phase[0];

endmodule : tcr_phase

`default_nettype wire

// ---- verilog/tcr_timer.sv ----
/*
  Second 16-bit timer/counter with capture, auto-reload (up or down)
  and baud clock source, reached through the special function bus.
  Assumes the bus strobes and the timer 1 overflow pulse are on mclk;
  count_input and trigger_input are raw port pins.
*/
`timescale 1ns/1ps
`default_nettype none

module tcr_timer
  import tcr_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic count_input,
  input wire logic trigger_input,
  input wire logic timer1_overflow,
  output logic rx_baud_tick,
  output logic tx_baud_tick,
  output logic timer_irq,
  output logic clock_out_enable
);

  // ==========================================================
  // Reset release
  logic rst_meta_n;
  logic rst_sync_n;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  // ==========================================================
  // Machine-cycle phases
  logic [3:0] phase;
  logic state_tick;
  logic at_sample;
  logic at_update;

  tcr_phase #(
    .CYCLE_LEN(OSC_PER_CYCLE)
  ) u_phase (
    .mclk(mclk),
    .rst_sync_n(rst_sync_n),
    .phase(phase),
    .state_tick(state_tick)
  );

  assign at_sample = (phase == PHASE_SAMPLE);
  assign at_update = (phase == PHASE_UPDATE);

  // ==========================================================
  // Pin synchronisers; pins idle high
  logic cnt_meta;
  logic cnt_sync;
  logic trg_meta;
  logic trg_sync;

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cnt_meta <= 1'b1;
      cnt_sync <= 1'b1;
      trg_meta <= 1'b1;
      trg_sync <= 1'b1;
    end else begin
      cnt_meta <= count_input;
      cnt_sync <= cnt_meta;
      trg_meta <= trigger_input;
      trg_sync <= trg_meta;
    end
  end

  // ==========================================================
  // Registers
  tcr_ctrl_s ctrl;
  logic down_count_enable;
  logic out_enable;
  logic [7:0] count_high;
  logic [7:0] count_low;
  logic [7:0] holding_high;
  logic [7:0] holding_low;
  logic [15:0] count;
  logic [15:0] holding;

  assign count = {count_high, count_low};
  assign holding = {holding_high, holding_low};

  function automatic logic wr_hit(input logic [7:0] a);
    wr_hit = sfr_wr && (sfr_addr == a);
  endfunction : wr_hit

  // ==========================================================
  // Mode decode
  tcr_mode_e mode;
  logic serial_sel;
  logic up_down;

  assign serial_sel = ctrl.rx_clock_select | ctrl.tx_clock_select;

  always_comb begin
    if (!ctrl.run_control) begin
      mode = TCR_OFF;
    end else if (serial_sel) begin
      mode = TCR_BAUD;
    end else if (ctrl.capture_reload_select) begin
      mode = TCR_CAPTURE;
    end else begin
      mode = TCR_RELOAD;
    end
  end

  // Up/down only applies in auto-reload
  assign up_down = down_count_enable && !serial_sel &&
    !ctrl.capture_reload_select;

  // ==========================================================
  // Edge detection on machine-cycle samples
  logic cnt_prev;
  logic cnt_pending;
  logic trg_prev;
  logic trg_pending;

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cnt_prev <= 1'b1;
      cnt_pending <= 1'b0;
    end else if (at_sample) begin
      cnt_prev <= cnt_sync;
      if (cnt_prev && !cnt_sync) begin
        cnt_pending <= 1'b1;
      end
    end else if (at_update) begin
      cnt_pending <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      trg_prev <= 1'b1;
      trg_pending <= 1'b0;
    end else if (at_sample) begin
      trg_prev <= trg_sync;
      if (trg_prev && !trg_sync) begin
        trg_pending <= 1'b1;
      end
    end else if (at_update) begin
      trg_pending <= 1'b0;
    end
  end

  // ==========================================================
  // Count events
  logic inc_evt;
  logic trig_evt;
  logic count_down;
  logic rollover;
  logic ovf_pulse;
  logic [15:0] next_count;

  always_comb begin
    inc_evt = 1'b0;
    if (mode != TCR_OFF) begin
      if (ctrl.counter_select) begin
        inc_evt = at_update && cnt_pending;
      end else if (mode == TCR_BAUD) begin
        inc_evt = state_tick;
      end else begin
        inc_evt = at_update;
      end
    end
  end

  // Trigger acts only while enabled; up/down uses it as direction
  assign trig_evt = at_update && trg_pending &&
    ctrl.ext_trigger_enable && !up_down;

  assign count_down = up_down && !trg_sync;
  assign rollover = inc_evt &&
    (count_down ? (count == holding) : (count == COUNT_ALL_ONES));
  assign ovf_pulse = rollover;

  always_comb begin
    next_count = count;
    if (inc_evt) begin
      if (count_down) begin
        next_count = rollover ? COUNT_ALL_ONES : count - 16'h0001;
      end else if (rollover && mode != TCR_CAPTURE) begin
        next_count = holding;
      end else begin
        next_count = count + 16'h0001;
      end
    end
    // Trigger reload; baud mode never reloads from the trigger
    if (trig_evt && mode != TCR_BAUD && !serial_sel &&
        !ctrl.capture_reload_select) begin
      next_count = holding;
    end
  end

  // ==========================================================
  // Counter registers; a software write beats the hardware update
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      count_low <= RST_BYTE;
    end else if (wr_hit(ADDR_COUNT_LOW)) begin
      count_low <= sfr_wdata;
    end else begin
      count_low <= next_count[7:0];
    end
  end

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      count_high <= RST_BYTE;
    end else if (wr_hit(ADDR_COUNT_HIGH)) begin
      count_high <= sfr_wdata;
    end else begin
      count_high <= next_count[15:8];
    end
  end

  // ==========================================================
  // Holding pair; a capture beats a software write
  logic capture_evt;

  assign capture_evt = trig_evt && !serial_sel &&
    ctrl.capture_reload_select;

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      holding_low <= RST_BYTE;
      holding_high <= RST_BYTE;
    end else if (capture_evt) begin
      holding_low <= count_low;
      holding_high <= count_high;
    end else begin
      if (wr_hit(ADDR_HOLD_LOW)) begin
        holding_low <= sfr_wdata;
      end
      if (wr_hit(ADDR_HOLD_HIGH)) begin
        holding_high <= sfr_wdata;
      end
    end
  end

  // ==========================================================
  // Control register; hardware set wins over software clear
  logic set_overflow;
  logic set_external;
  logic toggle_external;

  assign set_overflow = ovf_pulse && !serial_sel;
  // In baud mode the trigger still flags, with no reload
  assign set_external = trig_evt;
  assign toggle_external = ovf_pulse && up_down;

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ctrl <= tcr_ctrl_s'(RST_CONTROL);
    end else begin
      if (wr_hit(ADDR_CONTROL)) begin
        ctrl <= tcr_ctrl_s'(sfr_wdata);
      end
      if (set_overflow) begin
        ctrl.overflow_flag <= 1'b1;
      end
      if (set_external) begin
        ctrl.external_flag <= 1'b1;
      end else if (toggle_external) begin
        ctrl.external_flag <= (wr_hit(ADDR_CONTROL) ?
          sfr_wdata[BIT_EXTERNAL] : ctrl.external_flag) ^ 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      down_count_enable <= RST_MODE[BIT_DOWN_EN];
      out_enable <= RST_MODE[BIT_OUT_EN];
    end else if (wr_hit(ADDR_MODE)) begin
      down_count_enable <= sfr_wdata[BIT_DOWN_EN];
      out_enable <= sfr_wdata[BIT_OUT_EN];
    end
  end

  // ==========================================================
  // Read port: data one cycle after the read strobe
  logic [7:0] next_rdata;

  always_comb begin
    case (sfr_addr)
      ADDR_CONTROL: next_rdata = ctrl;
      ADDR_MODE: next_rdata = {6'h00, out_enable, down_count_enable};
      ADDR_HOLD_LOW: next_rdata = holding_low;
      ADDR_HOLD_HIGH: next_rdata = holding_high;
      ADDR_COUNT_LOW: next_rdata = count_low;
      ADDR_COUNT_HIGH: next_rdata = count_high;
      default: next_rdata = RST_UNMAPPED;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      sfr_rdata <= RST_UNMAPPED;
    end else if (sfr_rd) begin
      sfr_rdata <= next_rdata;
    end
  end

  // ==========================================================
  // Serial clock routing and interrupt request
  logic rx_tick;
  logic tx_tick;
  logic irq;

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rx_tick <= 1'b0;
      tx_tick <= 1'b0;
      irq <= 1'b0;
    end else begin
      rx_tick <= ctrl.rx_clock_select ? ovf_pulse : timer1_overflow;
      tx_tick <= ctrl.tx_clock_select ? ovf_pulse : timer1_overflow;
      // Enable gating lives in the interrupt controller
      irq <= ctrl.overflow_flag ||
        (ctrl.external_flag && !down_count_enable);
    end
  end

  assign rx_baud_tick = rx_tick;
  assign tx_baud_tick = tx_tick;
  assign timer_irq = irq;
  assign clock_out_enable = out_enable;

endmodule : tcr_timer

`default_nettype wire

// ---- verif/tcr_pins_model.sv ----
/*
  Far-side model of the count and trigger pins.
  Assumes the bench calls pin_fall; pins idle high on their pull-ups.
*/
`timescale 1ns/1ps
`default_nettype none

module tcr_pins_model (
  input wire logic mclk,
  output logic count_input,
  output logic trigger_input
);
  initial begin
    count_input = 1'b1;
    trigger_input = 1'b1;
  end

  // Low then high, each level two machine cycles, above the minimum
  task automatic pin_fall(input bit trig);
    @(negedge mclk);
    trigger_input = trig ? 1'b0 : trigger_input;
    count_input = trig ? count_input : 1'b0;
    repeat (24) @(negedge mclk);
    trigger_input = 1'b1;
    count_input = 1'b1;
    repeat (24) @(negedge mclk);
  endtask : pin_fall

  // Count fall framed by a low trigger, so up/down counts down
  task automatic count_down_fall;
    @(negedge mclk);
    trigger_input = 1'b0;
    repeat (24) @(negedge mclk);
    count_input = 1'b0;
    repeat (24) @(negedge mclk);
    count_input = 1'b1;
    repeat (24) @(negedge mclk);
    trigger_input = 1'b1;
    repeat (24) @(negedge mclk);
  endtask : count_down_fall
endmodule : tcr_pins_model

`default_nettype wire

// ---- verif/tcr_timer_checker.sv ----
/*
  Port-level assertions for the second timer/counter.
  Assumes it is bound to tcr_timer and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none

module tcr_timer_checker
  import tcr_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic timer1_overflow,
  input wire logic rx_baud_tick,
  input wire logic tx_baud_tick,
  input wire logic timer_irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // ==========================================================
  // Shadows of software-only bits; flags are judged between reads
  wire wr_c = sfr_wr && sfr_addr == ADDR_CONTROL;
  wire wr_n = sfr_wr && (sfr_addr == ADDR_COUNT_LOW ||
    sfr_addr == ADDR_COUNT_HIGH);
  logic rx_sh, tx_sh, run_sh, down_count_enable_sh, rd_c, rd_l, clean_c, clean_l;
  logic [1:0] prev_f;
  logic [7:0] prev_l;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      {rx_sh, tx_sh, run_sh, down_count_enable_sh} <= 4'h0;
    end else begin
      if (wr_c) begin
        {rx_sh, tx_sh, run_sh} <= {sfr_wdata[5:4], sfr_wdata[2]};
      end
      if (sfr_wr && sfr_addr == ADDR_MODE) begin
        down_count_enable_sh <= sfr_wdata[BIT_DOWN_EN];
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      {rd_c, rd_l, clean_c, clean_l} <= 4'h0;
      prev_f <= 2'h0;
      prev_l <= 8'h00;
    end else begin
      rd_c <= sfr_rd && sfr_addr == ADDR_CONTROL;
      rd_l <= sfr_rd && sfr_addr == ADDR_COUNT_LOW;
      prev_f <= rd_c ? sfr_rdata[7:6] : prev_f;
      prev_l <= rd_l ? sfr_rdata : prev_l;
      clean_c <= wr_c ? 1'b0 : (rd_c | clean_c);
      clean_l <= (wr_c | wr_n) ? 1'b0 : (rd_l | clean_l);
    end
  end

  // ==========================================================
  // Properties
  sequence s_ctrl_read;
    sfr_rd && sfr_addr == ADDR_CONTROL ##1 1'b1;
  endsequence
  property p_irq_value;
    s_ctrl_read |-> timer_irq == (sfr_rdata[BIT_OVERFLOW] |
      (sfr_rdata[BIT_EXTERNAL] & !$past(down_count_enable_sh)));
  endproperty
  property p_flags_sticky;
    rd_c && clean_c |-> (prev_f & {1'b1, !down_count_enable_sh} & ~sfr_rdata[7:6]) == 2'h0;
  endproperty
  property p_baud_no_flag;
    rd_c && clean_c && (rx_sh || tx_sh) |-> sfr_rdata[7] == prev_f[1];
  endproperty
  property p_stopped_count;
    rd_l && clean_l && !run_sh |-> sfr_rdata == prev_l;
  endproperty
  property p_rdata_hold;
    !sfr_rd |=> $stable(sfr_rdata);
  endproperty
  property p_unmapped;
    sfr_rd && (sfr_addr < ADDR_CONTROL || sfr_addr > ADDR_COUNT_HIGH)
      |=> sfr_rdata == RST_UNMAPPED;
  endproperty
  property p_rx_route;
    !rx_sh |=> rx_baud_tick == $past(timer1_overflow);
  endproperty
  property p_tx_route;
    !tx_sh |=> tx_baud_tick == $past(timer1_overflow);
  endproperty

  a_irq_value: assert property (p_irq_value)
    else $error("timer_irq disagrees with flags");
  a_flags_sticky: assert property (p_flags_sticky)
    else $error("flag cleared without a write");
  a_baud_no_flag: assert property (p_baud_no_flag)
    else $error("overflow flag set in baud mode");
  a_stopped_count: assert property (p_stopped_count)
    else $error("count moved while stopped");
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data changed without a read");
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  a_rx_route: assert property (p_rx_route)
    else $error("receiver tick not from timer 1");
  a_tx_route: assert property (p_tx_route)
    else $error("transmitter tick not from timer 1");
endmodule : tcr_timer_checker

bind tcr_timer tcr_timer_checker u_chk (.mclk(mclk), .rst_n(rst_n),
  .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
  .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
  .timer1_overflow(timer1_overflow), .rx_baud_tick(rx_baud_tick),
  .tx_baud_tick(tx_baud_tick), .timer_irq(timer_irq));

`default_nettype wire

// ---- verif/tcr_timer_test.sv ----
/*
  Self-checking bench for the second timer/counter.
  Assumes tcr_pins_model drives the pins and the checker is bound.
*/
`timescale 1ns/1ps
`default_nettype none

module tcr_timer_test
  import tcr_pkg::*;
;
  logic mclk = 1'b0;
  logic rst_n;
  logic sfr_wr;
  logic sfr_rd;
  logic timer1_overflow;
  logic [7:0] sfr_addr;
  logic [7:0] sfr_wdata;
  logic [7:0] sfr_rdata;
  logic count_input, trigger_input, rx_baud_tick, tx_baud_tick;
  logic timer_irq, clock_out_enable;
  int fail_count = 0;
  int checks = 0;
  int rx_ticks = 0;
  int tx_ticks = 0;

  always #4 mclk = ~mclk;
  always @(posedge mclk) begin
    rx_ticks = rx_ticks + int'(rx_baud_tick === 1'b1);
    tx_ticks = tx_ticks + int'(tx_baud_tick === 1'b1);
  end

  tcr_timer dut (.mclk(mclk), .rst_n(rst_n), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .count_input(count_input),
    .trigger_input(trigger_input), .timer1_overflow(timer1_overflow),
    .rx_baud_tick(rx_baud_tick), .tx_baud_tick(tx_baud_tick),
    .timer_irq(timer_irq), .clock_out_enable(clock_out_enable));
  tcr_pins_model pins (.mclk(mclk), .count_input(count_input),
    .trigger_input(trigger_input));

  // ==========================================================
  // Bus tasks and comparison
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge mclk);
    sfr_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge mclk);
    d = sfr_rdata;
    sfr_rd = 1'b0;
  endtask : rd
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    checks++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr16(input logic [7:0] a, input logic [15:0] d);
    wr(a, d[7:0]);
    wr(8'(a + 8'h01), d[15:8]);
  endtask : wr16
  task automatic rc(input string n, input logic [7:0] a, input logic [15:0] e);
    logic [15:0] v;
    rd(a, v[7:0]);
    v[15:8] = 8'h00;
    if (e[15:8] != 8'h00 || a == ADDR_HOLD_LOW || a == ADDR_COUNT_LOW) begin
      rd(8'(a + 8'h01), v[15:8]);
    end
    chk(n, v, e);
  endtask : rc
  task automatic finish_test;
    if (fail_count == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : finish_test

  // Generous bound; the sequence needs under 3000 clocks
  initial begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    finish_test();
  end

  // ==========================================================
  // Scenarios
  initial begin
    rst_n = 1'b0;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    timer1_overflow = 1'b0;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    repeat (3) @(negedge mclk);
    rst_n = 1'b1;
    repeat (4) @(negedge mclk);
    for (int i = 0; i < 7; i++) rc("reset", 8'(8'hC8 + i), 16'h0000);
    wr16(ADDR_HOLD_LOW, 16'h1234);
    rc("hold", ADDR_HOLD_LOW, 16'h1234);
    wr16(ADDR_COUNT_LOW, 16'hFFFF);
    wr(ADDR_CONTROL, 8'h06);
    pins.pin_fall(1'b0);
    rc("reload", ADDR_COUNT_LOW, 16'h1234);
    rc("ovf", ADDR_CONTROL, 16'h0086);
    chk("irq", 16'(timer_irq), 16'h0001);
    wr(ADDR_CONTROL, 8'h00);
    rc("clear", ADDR_CONTROL, 16'h0000);
    // Trigger reload in auto-reload mode
    wr16(ADDR_COUNT_LOW, 16'h0200);
    wr(ADDR_CONTROL, 8'h0E);
    pins.pin_fall(1'b1);
    rc("trig reload", ADDR_COUNT_LOW, 16'h1234);
    rc("trig ext", ADDR_CONTROL, 16'h004E);
    wr(ADDR_CONTROL, 8'h00);
    // Run spans exactly 120 clocks, ten machine cycles
    wr16(ADDR_COUNT_LOW, 16'h0100);
    wr(ADDR_CONTROL, 8'h04);
    repeat (118) @(negedge mclk);
    wr(ADDR_CONTROL, 8'h00);
    rc("timer", ADDR_COUNT_LOW, 16'h010A);
    repeat (50) @(negedge mclk);
    rc("stopped", ADDR_COUNT_LOW, 16'h010A);
    wr16(ADDR_COUNT_LOW, 16'h0155);
    wr(ADDR_CONTROL, 8'h0F);
    repeat (3) pins.pin_fall(1'b0);
    pins.pin_fall(1'b1);
    rc("capture", ADDR_HOLD_LOW, 16'h0158);
    rc("ext", ADDR_CONTROL, 16'h004F);
    wr(ADDR_CONTROL, 8'h0F);
    wr16(ADDR_COUNT_LOW, 16'hFFFF);
    pins.pin_fall(1'b0);
    rc("wrap", ADDR_COUNT_LOW, 16'h0000);
    rc("kept", ADDR_HOLD_LOW, 16'h0158);
    rc("wrap ovf", ADDR_CONTROL, 16'h008F);
    wr(ADDR_CONTROL, 8'h07);
    pins.pin_fall(1'b1);
    rc("ignored", ADDR_HOLD_LOW, 16'h0158);
    rc("no ext", ADDR_CONTROL, 16'h0007);
    // Up/down enable must mask the external flag only
    wr(ADDR_CONTROL, 8'h0F);
    pins.pin_fall(1'b1);
    chk("ext irq", 16'(timer_irq), 16'h0001);
    wr(ADDR_MODE, 8'h01);
    @(negedge mclk);
    chk("down_count_enable irq", 16'(timer_irq), 16'h0000);
    wr(ADDR_MODE, 8'h02);
    @(negedge mclk);
    chk("oe", 16'(clock_out_enable), 16'h0001);
    rc("mode", ADDR_MODE, 16'h0002);
    wr(ADDR_MODE, 8'h00);
    wr(ADDR_CONTROL, 8'h00);
    // Up/down: trigger low counts down, underflow reloads all ones
    wr16(ADDR_HOLD_LOW, 16'h0010);
    wr16(ADDR_COUNT_LOW, 16'h0010);
    wr(ADDR_MODE, 8'h01);
    wr(ADDR_CONTROL, 8'h06);
    pins.count_down_fall();
    rc("underflow", ADDR_COUNT_LOW, 16'hFFFF);
    rc("toggle", ADDR_CONTROL, 16'h00C6);
    pins.pin_fall(1'b0);
    rc("up reload", ADDR_COUNT_LOW, 16'h0010);
    rc("toggle back", ADDR_CONTROL, 16'h0086);
    wr(ADDR_CONTROL, 8'h00);
    wr(ADDR_MODE, 8'h00);
    // Baud mode: capture select set but reload forced
    wr16(ADDR_HOLD_LOW, 16'hFFF0);
    wr16(ADDR_COUNT_LOW, 16'hFFF0);
    rx_ticks = 0;
    tx_ticks = 0;
    wr(ADDR_CONTROL, 8'h35);
    repeat (200) @(negedge mclk);
    wr(ADDR_CONTROL, 8'h31);
    chk("rx ticks", 16'(rx_ticks >= 5), 16'h0001);
    chk("tx ticks", 16'(tx_ticks), 16'(rx_ticks));
    rc("baud high", ADDR_COUNT_HIGH, 16'h00FF);
    repeat (2) rc("no ovf", ADDR_CONTROL, 16'h0031);
    wr(ADDR_CONTROL, 8'h00);
    rx_ticks = 0;
    tx_ticks = 0;
    repeat (3) begin
      @(negedge mclk);
      timer1_overflow = 1'b1;
      @(negedge mclk);
      timer1_overflow = 1'b0;
    end
    @(negedge mclk);
    chk("rx t1", 16'(rx_ticks), 16'h0003);
    chk("tx t1", 16'(tx_ticks), 16'h0003);
    finish_test();
  end
endmodule : tcr_timer_test

`default_nettype wire
